/* sdmpr_pkg.sv */
// Purpose : Shared constants and types of the pattern-register / DLL-off command block
// Assumes : One command per i_ref_clk edge, 100 MHz
// Notes   : Times are kept in their own unit and all but CLOCK_VALID_SR_NS turned into cycles here
package sdmpr_pkg;

    // ==========================================================
    // Clock
    localparam int CLK_PERIOD_NS = 10;

    // ==========================================================
    // Command address layout
    localparam int ADDR_W = 14;
    localparam int BA_W   = 3;
    localparam int DQ_W   = 16;
    localparam int LANE_W = 8;
    localparam int LAT_W  = 5;
    localparam int STAMP_W = 8;

    localparam logic [BA_W-1:0] MR0_SEL = 3'h0;
    localparam logic [BA_W-1:0] MR1_SEL = 3'h1;
    localparam logic [BA_W-1:0] MR3_SEL = 3'h3;

    localparam int MR3_PATTERN_EN_BIT = 2;
    localparam int MR3_LOC_LSB        = 0;
    localparam int MR1_DLL_OFF_BIT    = 0;
    localparam int ADDR_NIBBLE_BIT    = 2;
    localparam int ADDR_BC_BIT        = 12;

    // ==========================================================
    // Reset values
    localparam logic       PATTERN_EN_RST = 1'b0;
    localparam logic [1:0] LOC_RST        = 2'h0;
    localparam logic       DLL_OFF_RST    = 1'b0;

    // ==========================================================
    // Pattern register contents, beat 0 in the LSB
    localparam logic [7:0] CAL_PATTERN   = 8'hAA;
    localparam logic [1:0] LOC_CAL       = 2'h0;
    localparam logic [7:0] RESERVED_DATA = 8'h00;
    localparam logic [3:0] BEATS_BL8     = 4'h8;
    localparam logic [3:0] BEATS_BC4     = 4'h4;
    localparam logic [2:0] BEAT_LOW      = 3'h0;
    localparam logic [2:0] BEAT_HIGH     = 3'h4;

    // ==========================================================
    // DLL-off latency limits
    localparam logic [LAT_W-1:0] DLL_OFF_CL  = 5'h06;
    localparam logic [LAT_W-1:0] DLL_OFF_CWL = 5'h06;
    localparam logic [LAT_W-1:0] MIN_READ_LAT = 5'h02;

    // ==========================================================
    // Controller-side timing, kept for reference by both ends
    localparam int LEVEL_FIRST_STROBE_CK  = 40;
    localparam int LEVEL_STROBE_EN_CK     = 25;
    localparam int REFRESH_CYCLE_NS       = 160;
    localparam int REFRESH_CYCLE_CYC      = (REFRESH_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int AVG_REFRESH_NORMAL_NS  = 7800;
    localparam int AVG_REFRESH_HOT_NS     = 3900;
    localparam int AVG_REFRESH_NORMAL_CYC = AVG_REFRESH_NORMAL_NS / CLK_PERIOD_NS;
    localparam int AVG_REFRESH_HOT_CYC    = AVG_REFRESH_HOT_NS / CLK_PERIOD_NS;
    localparam int CLOCK_VALID_SR_CK      = 5;
    localparam int CLOCK_VALID_SR_NS      = 10;
    localparam int SR_EXIT_MIN_CK         = 5;
    localparam int SR_EXIT_EXTRA_NS       = 10;
    localparam int SR_EXIT_NS_CYC         =
        (REFRESH_CYCLE_NS + SR_EXIT_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SR_EXIT_WAIT_CYC       =
        (SR_EXIT_NS_CYC > SR_EXIT_MIN_CK) ? SR_EXIT_NS_CYC : SR_EXIT_MIN_CK;
    localparam int MODE_SET_DELAY_CYC     = 12;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        SDMPR_BURST_BL8,
        SDMPR_BURST_OTF,
        SDMPR_BURST_BC4
    } sdmpr_burst_t;

    typedef enum logic [2:0] {
        SDMPR_CMD_MRS,
        SDMPR_CMD_REF,
        SDMPR_CMD_PRE,
        SDMPR_CMD_ACT,
        SDMPR_CMD_WR,
        SDMPR_CMD_RD,
        SDMPR_CMD_ZQ,
        SDMPR_CMD_NOP
    } sdmpr_cmd_t;

    typedef struct packed {
        logic [1:0]         loc;
        logic               start_high;
        logic               chop;
        logic [STAMP_W-1:0] stamp;
    } sdmpr_req_t;

endpackage

/* sdmpr_fifo.sv */
// Purpose : Small valid/ready FIFO for queued pattern reads
// Assumes : DEPTH is a power of two
// Notes   : Full and empty come from an occupancy count, no bypass path
module sdmpr_fifo
    import sdmpr_pkg::*;
#(
    parameter int WIDTH = 12,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst_b,
    // Fill side
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    // Drain side
    output logic                  o_out_valid,
    output logic [WIDTH-1:0]      o_out_data,
    input  wire logic             i_out_ready
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [PTR_W:0]   count_reg;
    logic             push;
    logic             pop;

    assign o_in_ready  = (count_reg != (PTR_W+1)'(DEPTH));
    assign o_out_valid = (count_reg != '0);
    assign o_out_data  = mem_reg[rd_ptr_reg];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= i_in_data;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
        end
    end

endmodule

/* sdmpr_serializer.sv */
// Purpose : Turns one queued pattern read into a burst of beats on the data lanes
// Assumes : One beat per i_ref_clk cycle
// Notes   : At least one idle cycle separates two bursts
module sdmpr_serializer
    import sdmpr_pkg::*;
(
    // Clock and reset
    input  wire logic            i_ref_clk,
    input  wire logic            i_rst_b,
    // Request
    input  wire logic            i_req_valid,
    input  wire sdmpr_req_t      i_req,
    output logic                 o_req_ready,
    // Lane fill choice
    input  wire logic            i_replicate,
    // Data lanes
    output logic [DQ_W-1:0]      o_dq,
    output logic                 o_dq_oe
);
    logic [7:0] pattern_reg;
    logic [2:0] beat_reg;
    logic [3:0] left_reg;
    logic       bit_now;
    logic       start;

    assign o_req_ready = (left_reg == '0);
    assign start       = i_req_valid && o_req_ready;
    assign bit_now     = pattern_reg[beat_reg];

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            pattern_reg <= '0;
            beat_reg    <= '0;
            left_reg    <= '0;
        end else if (start) begin
            // Reserved locations have no defined content; they read as zero
            pattern_reg <= (i_req.loc == LOC_CAL) ? CAL_PATTERN : RESERVED_DATA;
            beat_reg    <= (i_req.chop && i_req.start_high) ? BEAT_HIGH : BEAT_LOW;
            left_reg    <= i_req.chop ? BEATS_BC4 : BEATS_BL8;
        end else if (left_reg != '0) begin
            beat_reg <= beat_reg + 1'b1;
            left_reg <= left_reg - 1'b1;
        end
    end

    // Bit 0 of each lane carries the beat; upper bits copy it or stay low
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_dq    <= '0;
            o_dq_oe <= 1'b0;
        end else begin
            o_dq_oe <= (left_reg != '0);
            for (int l = 0; l < DQ_W / LANE_W; l++) begin
                o_dq[l*LANE_W]                 <= (left_reg != '0) && bit_now;
                o_dq[l*LANE_W+1 +: LANE_W-1]   <= {(LANE_W-1){(left_reg != '0) && bit_now
                                                    && i_replicate}};
            end
        end
    end

endmodule

/* sdmpr_core.sv */
// Purpose : Device-side command decoder for pattern-register reads and DLL-off mode
// Assumes : Commands sampled on each i_ref_clk edge; burst mode and latencies come in as ports
// Notes   : Pattern reads queue in a small FIFO and leave one beat per cycle
module sdmpr_core
    import sdmpr_pkg::*;
#(
    parameter int FIFO_DEPTH    = 4,
    parameter int SR_EXIT_CYC   = SR_EXIT_WAIT_CYC,
    parameter int MODE_SET_CYC  = MODE_SET_DELAY_CYC
) (
    // Clock and reset
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst_b,
    // Command pins
    input  wire logic              i_cke,
    input  wire logic              i_cs_b,
    input  wire logic              i_ras_b,
    input  wire logic              i_cas_b,
    input  wire logic              i_we_b,
    input  wire logic [BA_W-1:0]   i_ba,
    input  wire logic [ADDR_W-1:0] i_addr,
    // Configuration
    input  wire sdmpr_burst_t      i_burst_mode,
    input  wire logic [LAT_W-1:0]  i_cas_latency,
    input  wire logic [LAT_W-1:0]  i_cas_write_latency,
    input  wire logic [LAT_W-1:0]  i_additive_latency,
    input  wire logic              i_replicate_lanes,
    // Forwarded array commands
    output logic                   o_array_cmd_valid,
    output sdmpr_cmd_t             o_array_cmd,
    output logic [BA_W-1:0]        o_array_ba,
    output logic [ADDR_W-1:0]      o_array_addr,
    // Read data lanes
    output logic [DQ_W-1:0]        o_dq,
    output logic                   o_dq_oe,
    // Status
    output logic                   o_pattern_enabled,
    output logic [1:0]             o_pattern_loc,
    output logic                   o_dll_off,
    output logic [LAT_W-1:0]       o_read_latency,
    output logic                   o_latency_error,
    output logic                   o_in_self_refresh,
    output logic                   o_mode_busy,
    output logic                   o_illegal_cmd,
    output logic                   o_read_dropped
);
    // ==========================================================
    // Command decode
    typedef enum logic [1:0] {
        SDMPR_ST_ACTIVE,
        SDMPR_ST_SELF_REFRESH,
        SDMPR_ST_SR_EXIT
    } sdmpr_state_t;

    localparam int SR_CNT_W   = $clog2(SR_EXIT_CYC + 1);
    localparam int MODE_CNT_W = $clog2(MODE_SET_CYC + 1);

    sdmpr_state_t          state_reg;
    logic                  cke_prev_reg;
    logic                  selected;
    sdmpr_cmd_t            cmd;
    logic                  is_mrs;
    logic                  is_read;
    logic                  is_sr_entry;
    logic                  is_sr_exit;
    logic                  chop;
    logic                  pattern_en_reg;
    logic [1:0]            pattern_loc_reg;
    logic                  dll_off_reg;
    logic [STAMP_W-1:0]    now_reg;
    logic [LAT_W-1:0]      read_lat_next;
    logic [SR_CNT_W-1:0]   sr_cnt_reg;
    logic [MODE_CNT_W-1:0] mode_cnt_reg;
    logic                  illegal;
    sdmpr_req_t            push_req;
    logic                  push_valid;
    logic                  push_ready;
    sdmpr_req_t            head_req;
    logic                  head_valid;
    logic                  head_due;
    logic                  ser_ready;

    // Deselect and power-down leave the decoder with nothing to register
    assign selected = !i_cs_b && i_cke && cke_prev_reg;
    assign cmd      = sdmpr_cmd_t'({i_ras_b, i_cas_b, i_we_b});
    assign is_mrs   = selected && (cmd == SDMPR_CMD_MRS);
    assign is_read  = selected && (cmd == SDMPR_CMD_RD);
    assign is_sr_entry = !i_cs_b && cke_prev_reg && !i_cke && (cmd == SDMPR_CMD_REF);
    assign is_sr_exit  = (state_reg == SDMPR_ST_SELF_REFRESH) && i_cke;

    // Chop is fixed by mode or picked per read by bit 12 (low means chop)
    always_comb begin
        unique case (i_burst_mode)
            SDMPR_BURST_BC4: chop = 1'b1;
            SDMPR_BURST_OTF: chop = !i_addr[ADDR_BC_BIT];
            default:         chop = 1'b0;
        endcase
    end

    // Anything but a read, no-op or an MR3 mode set is refused in pattern mode
    always_comb begin
        illegal = 1'b0;
        if (pattern_en_reg) begin
            if (selected && !(cmd == SDMPR_CMD_RD || cmd == SDMPR_CMD_NOP)) begin
                illegal = !(is_mrs && i_ba == MR3_SEL);
            end
            if (is_sr_entry || (cke_prev_reg && !i_cke)) begin
                illegal = 1'b1;
            end
        end
        if (state_reg == SDMPR_ST_SR_EXIT && selected && cmd != SDMPR_CMD_NOP) begin
            illegal = 1'b1;
        end
    end

    // ==========================================================
    // Mode register state
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            pattern_en_reg  <= PATTERN_EN_RST;
            pattern_loc_reg <= LOC_RST;
        end else if (is_mrs && i_ba == MR3_SEL) begin
            pattern_en_reg  <= i_addr[MR3_PATTERN_EN_BIT];
            pattern_loc_reg <= i_addr[MR3_LOC_LSB +: 2];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            dll_off_reg <= DLL_OFF_RST;
        end else if (is_mrs && i_ba == MR1_SEL) begin
            dll_off_reg <= i_addr[MR1_DLL_OFF_BIT];
        end
    end

    // Mode-set delay: commands during it are the controller's problem, shown as busy
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            mode_cnt_reg <= '0;
        end else if (is_mrs) begin
            mode_cnt_reg <= MODE_CNT_W'(MODE_SET_CYC);
        end else if (mode_cnt_reg != '0) begin
            mode_cnt_reg <= mode_cnt_reg - 1'b1;
        end
    end

    // ==========================================================
    // Read latency
    always_comb begin
        read_lat_next = i_additive_latency + i_cas_latency;
        if (dll_off_reg) begin
            read_lat_next = read_lat_next - 1'b1;
        end
        if (read_lat_next < MIN_READ_LAT) begin
            read_lat_next = MIN_READ_LAT;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_read_latency  <= MIN_READ_LAT;
            o_latency_error <= 1'b0;
        end else begin
            o_read_latency  <= read_lat_next;
            // Only one latency pair is guaranteed once the loop is off
            o_latency_error <= dll_off_reg && (i_cas_latency != DLL_OFF_CL
                               || i_cas_write_latency != DLL_OFF_CWL);
        end
    end

    // ==========================================================
    // Self refresh tracking
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            state_reg    <= SDMPR_ST_ACTIVE;
            sr_cnt_reg   <= '0;
            cke_prev_reg <= 1'b1;
        end else begin
            cke_prev_reg <= i_cke;
            unique case (state_reg)
                SDMPR_ST_ACTIVE: begin
                    if (is_sr_entry) begin
                        state_reg <= SDMPR_ST_SELF_REFRESH;
                    end
                end
                SDMPR_ST_SELF_REFRESH: begin
                    if (is_sr_exit) begin
                        state_reg  <= SDMPR_ST_SR_EXIT;
                        sr_cnt_reg <= SR_CNT_W'(SR_EXIT_CYC);
                    end
                end
                SDMPR_ST_SR_EXIT: begin
                    if (sr_cnt_reg <= SR_CNT_W'(1)) begin
                        state_reg  <= SDMPR_ST_ACTIVE;
                        sr_cnt_reg <= '0;
                    end else begin
                        sr_cnt_reg <= sr_cnt_reg - 1'b1;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Array command forwarding
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_array_cmd_valid <= 1'b0;
            o_array_cmd       <= SDMPR_CMD_NOP;
            o_array_ba        <= '0;
            o_array_addr      <= '0;
        end else begin
            // No-op and pattern reads never reach the array
            o_array_cmd_valid <= selected && cmd != SDMPR_CMD_NOP && cmd != SDMPR_CMD_MRS
                                 && !pattern_en_reg && state_reg == SDMPR_ST_ACTIVE;
            o_array_cmd       <= selected ? cmd : SDMPR_CMD_NOP;
            o_array_ba        <= i_ba;
            o_array_addr      <= i_addr;
        end
    end

    // ==========================================================
    // Pattern read queue
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            now_reg <= '0;
        end else begin
            now_reg <= now_reg + 1'b1;
        end
    end

    // Bank, column 9:3 and the autoprecharge bit play no part here
    assign push_valid          = is_read && pattern_en_reg;
    assign push_req.loc        = pattern_loc_reg;
    assign push_req.start_high = i_addr[ADDR_NIBBLE_BIT];
    assign push_req.chop       = chop;
    assign push_req.stamp      = now_reg;

    // A read leaves once its latency has run and the serializer is free, so close reads wait for the burst ahead
    assign head_due = head_valid
                      && ((now_reg - head_req.stamp) >= STAMP_W'(o_read_latency - 1'b1));

    sdmpr_fifo #(
        .WIDTH ($bits(sdmpr_req_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_ref_clk   (i_ref_clk),
        .i_rst_b     (i_rst_b),
        .i_in_valid  (push_valid),
        .i_in_data   (push_req),
        .o_in_ready  (push_ready),
        .o_out_valid (head_valid),
        .o_out_data  (head_req),
        .i_out_ready (ser_ready && head_due)
    );

    sdmpr_serializer u_ser (
        .i_ref_clk   (i_ref_clk),
        .i_rst_b     (i_rst_b),
        .i_req_valid (head_due),
        .i_req       (head_req),
        .o_req_ready (ser_ready),
        .i_replicate (i_replicate_lanes),
        .o_dq        (o_dq),
        .o_dq_oe     (o_dq_oe)
    );

    // ==========================================================
    // Status outputs
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_pattern_enabled <= PATTERN_EN_RST;
            o_pattern_loc     <= LOC_RST;
            o_dll_off         <= DLL_OFF_RST;
            o_in_self_refresh <= 1'b0;
            o_mode_busy       <= 1'b0;
            o_illegal_cmd     <= 1'b0;
            o_read_dropped    <= 1'b0;
        end else begin
            o_pattern_enabled <= pattern_en_reg;
            o_pattern_loc     <= pattern_loc_reg;
            o_dll_off         <= dll_off_reg;
            o_in_self_refresh <= (state_reg != SDMPR_ST_ACTIVE);
            o_mode_busy       <= (mode_cnt_reg != '0);
            o_illegal_cmd     <= illegal;
            // A full queue means the controller read faster than bursts drain
            o_read_dropped    <= push_valid && !push_ready;
        end
    end

endmodule

/* sdmpr_ctrl_model.sv */
// Purpose : Controller model driving the command pins of the core
// Assumes : Clock enable stays high; no self refresh
// Notes   : Releasing the bus deselects the core and inverts the last command, bank and address
module sdmpr_ctrl_model
    import sdmpr_pkg::*;
(
    // Clock
    input  wire logic         i_ref_clk,
    // Command pins
    output logic              o_cke,
    output logic              o_cs_b,
    output logic [2:0]        o_cmd,
    output logic [BA_W-1:0]   o_ba,
    output logic [ADDR_W-1:0] o_addr
);
    logic pattern_on = 1'b0;
    initial begin
        o_cke = 1'b1; // No power-down or self refresh is entered
        o_cs_b = 1'b1; // Never levels or refreshes; run is under one refresh interval
        {o_cmd, o_ba, o_addr} = 20'h0;
    end
    // ========================================
    // Command tasks
    task automatic issue(input logic [2:0] code, input logic [BA_W-1:0] ba,
                         input logic [ADDR_W-1:0] addr);
        @(posedge i_ref_clk);
        #1;
        if (pattern_on && code != 3'h5 && !(code == 3'h0 && ba == MR3_SEL)) return;
        o_cs_b = 1'b0;
        o_cmd = code;
        o_ba = ba;
        o_addr = (pattern_on && code == 3'h5) ? {addr[13:2], 2'h0} : addr;
        if (code == 3'h0 && ba == MR3_SEL) pattern_on = addr[2];
    endtask
    task automatic release_bus;
        @(posedge i_ref_clk);
        #1;
        o_cs_b = 1'b1;
        {o_cmd, o_ba, o_addr} = ~{o_cmd, o_ba, o_addr};
    endtask
endmodule

/* sdmpr_core_sva.sv */
// Purpose : Port-level assertions of the pattern/DLL-off core
// Assumes : Self refresh is not entered
// Notes   : Bound onto every instance of the core
module sdmpr_core_sva
    import sdmpr_pkg::*;
(
    // Watched ports
    input wire logic              i_ref_clk,
    input wire logic              i_rst_b,
    input wire logic              i_cke,
    input wire logic              i_cs_b,
    input wire logic              i_ras_b,
    input wire logic              i_cas_b,
    input wire logic              i_we_b,
    input wire logic [BA_W-1:0]   i_ba,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [LAT_W-1:0]  i_cas_latency,
    input wire logic [LAT_W-1:0]  i_cas_write_latency,
    input wire logic [LAT_W-1:0]  i_additive_latency,
    input wire logic              o_array_cmd_valid,
    input wire logic [DQ_W-1:0]   o_dq,
    input wire logic              o_dq_oe,
    input wire logic [1:0]        o_pattern_loc,
    input wire logic              o_pattern_enabled,
    input wire logic              o_dll_off,
    input wire logic [LAT_W-1:0]  o_read_latency,
    input wire logic              o_latency_error
);
    logic [2:0] code;
    logic       mrs;
    logic [3:0] run;
    assign code = {i_ras_b, i_cas_b, i_we_b};
    assign mrs = !i_cs_b && i_cke && code == 3'h0;
    always_ff @(posedge i_ref_clk) begin
        run <= o_dq_oe ? run + 4'h1 : 4'h0;
    end
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    AST_MODE_SET: assert property (mrs && i_ba == MR3_SEL |-> ##2
        o_pattern_enabled == $past(i_addr[2], 2) && o_pattern_loc == $past(i_addr[1:0], 2))
        else $error("pattern mode not taken from MR3");
    AST_DLL_BIT: assert property (mrs && i_ba == MR1_SEL |->
        ##2 o_dll_off == $past(i_addr[0], 2)) else $error("loop-off bit not taken");
    AST_NO_NEW_CMD: assert property ((i_cs_b || code == 3'h7) |=> !o_array_cmd_valid)
        else $error("idle command forwarded");
    AST_LANES: assert property (o_dq_oe |-> o_dq[15:8] == o_dq[7:0] &&
        (o_dq[7:1] == 7'h00 || o_dq[7:1] == {7{o_dq[0]}})) else $error("lane fill wrong");
    AST_BEATS: assert property (o_dq_oe |-> o_dq[0] == (o_pattern_loc == LOC_CAL &&
        $past(o_dq_oe) && !$past(o_dq[0]))) else $error("beat value wrong");
    AST_BURST_LEN: assert property ($fell(o_dq_oe) |-> run == 4'h4 || run == 4'h8)
        else $error("burst length wrong");
    AST_READ_LAT: assert property ($past(i_rst_b) && $stable(o_dll_off) &&
        $stable(i_cas_latency) && $stable(i_additive_latency) && i_cas_latency > 5'h03 |->
        o_read_latency == i_additive_latency + i_cas_latency - {4'h0, o_dll_off})
        else $error("read latency wrong");
    AST_LAT_ERR: assert property ($past(i_rst_b) && o_dll_off && $past(o_dll_off) &&
        $stable(i_cas_latency) && $stable(i_cas_write_latency) |-> o_latency_error ==
        (i_cas_latency != DLL_OFF_CL || i_cas_write_latency != DLL_OFF_CWL))
        else $error("latency error flag wrong");
endmodule
bind sdmpr_core sdmpr_core_sva u_sdmpr_core_sva (.*);

/* sdmpr_core_bench.sv */
// Purpose : Self-checking bench of the pattern/DLL-off core
// Assumes : Clock enable held high, no self refresh
// Notes   : Reads are judged beat by beat
module sdmpr_core_bench
    import sdmpr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_b, cke, cs_b, repl, acv, oe, oe_q, pen, dll, lerr, drop, busy;
    logic [2:0] cmd;
    logic [BA_W-1:0] ba, aba;
    logic [ADDR_W-1:0] addr, aadr;
    logic [LAT_W-1:0] cl, cwl, al, rlat;
    logic [DQ_W-1:0] dq;
    sdmpr_burst_t bmode;
    sdmpr_cmd_t acmd;
    int errors = 0, num_checks = 0, drops = 0, bursts = 0, b0;
    localparam logic [13:0] RA [6] = '{14'h0400, 14'h0004, 14'h0000, 14'h0000, 14'h1000, 14'h0004};
    sdmpr_ctrl_model u_sdmpr_ctrl_model (.i_ref_clk(clk), .o_cke(cke), .o_cs_b(cs_b),
        .o_cmd(cmd), .o_ba(ba), .o_addr(addr));
    sdmpr_core #(.SR_EXIT_CYC(3), .MODE_SET_CYC(2)) u_sdmpr_core (.i_ref_clk(clk),
        .i_rst_b(rst_b), .i_cke(cke), .i_cs_b(cs_b), .i_ras_b(cmd[2]), .i_cas_b(cmd[1]),
        .i_we_b(cmd[0]), .i_ba(ba), .i_addr(addr), .i_burst_mode(bmode), .i_cas_latency(cl),
        .i_cas_write_latency(cwl), .i_additive_latency(al), .i_replicate_lanes(repl),
        .o_array_cmd_valid(acv), .o_array_cmd(acmd), .o_array_ba(aba), .o_array_addr(aadr),
        .o_dq(dq), .o_dq_oe(oe), .o_pattern_enabled(pen), .o_pattern_loc(), .o_dll_off(dll),
        .o_read_latency(rlat), .o_latency_error(lerr), .o_in_self_refresh(), .o_mode_busy(busy),
        .o_illegal_cmd(), .o_read_dropped(drop));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        oe_q <= oe;
        if (oe === 1'b1 && oe_q === 1'b0) bursts <= bursts + 1;
        if (drop === 1'b1) drops <= drops + 1;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        if (errors == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic cmd1(input logic [2:0] c, input logic [2:0] b, input logic [13:0] a);
        u_sdmpr_ctrl_model.issue(c, b, a);
        u_sdmpr_ctrl_model.release_bus();
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic t_read(input logic [13:0] a, input logic [1:0] loc, input int lat);
        int n, len, first;
        logic b;
        len = (bmode == SDMPR_BURST_BC4 || (bmode == SDMPR_BURST_OTF && !a[12])) ? 4 : 8;
        first = (len == 4 && a[2]) ? 4 : 0;
        cmd1(3'h5, 3'h7, a);
        n = 0;
        do begin
            wait_n(1);
            n++;
        end while (oe !== 1'b1 && n < 40);
        chk(16'(n), 16'(lat));
        if (n >= 40) give_verdict();
        for (int i = first; i < first + len; i++) begin
            b = loc == LOC_CAL && CAL_PATTERN[i];
            chk(dq, repl ? {16{b}} : {7'h00, b, 7'h00, b});
            wait_n(1);
        end
        chk(oe, 1'b0);
    endtask
    initial begin
        rst_b = 1'b0;
        repl = 1'b0;
        bmode = SDMPR_BURST_BL8;
        {cl, cwl, al} = {5'h06, 5'h06, 5'h00};
        wait_n(4);
        chk(rlat, 16'h0002);
        rst_b = 1'b1;
        cmd1(3'h3, 3'h5, 14'h0123);
        chk({acv, acmd, aba}, {1'b1, SDMPR_CMD_ACT, 3'h5});
        chk(aadr, 14'h0123);
        wait_n(1);
        chk({acv, acmd}, {1'b0, SDMPR_CMD_NOP});
        cmd1(3'h7, 3'h0, 14'h0000);
        chk(acv, 1'b0);
        cmd1(3'h2, 3'h0, 14'h0400);
        for (int k = 0; k < 6; k++) begin
            bmode = sdmpr_burst_t'(k % 3);
            repl = 1'(k % 2);
            cmd1(3'h0, MR3_SEL, {11'h000, 1'b1, 2'(k % 4)});
            wait_n(2);
            chk(pen, 1'b1);
            t_read(RA[k], 2'(k % 4), 6);
        end
        cmd1(3'h0, MR3_SEL, 14'h0000);
        wait_n(2);
        chk(pen, 1'b0);
        cmd1(3'h5, 3'h0, 14'h0000);
        chk(acv, 1'b1);
        cmd1(3'h0, MR1_SEL, 14'h0001);
        wait_n(2);
        chk({dll, lerr, busy}, 3'h5);
        chk(rlat, 16'h0005);
        cl = 5'h07;
        wait_n(2);
        chk(lerr, 1'b1);
        cl = 5'h06;
        bmode = SDMPR_BURST_BL8;
        // Pattern reads only with the loop back on
        cmd1(3'h0, MR1_SEL, 14'h0000);
        cmd1(3'h0, MR3_SEL, 14'h0004);
        wait_n(2);
        t_read(14'h0000, LOC_CAL, 6);
        b0 = bursts;
        repeat (8) u_sdmpr_ctrl_model.issue(3'h5, 3'h0, 14'h0000);
        u_sdmpr_ctrl_model.release_bus();
        wait_n(120);
        chk(16'(bursts - b0 + drops), 16'h0008);
        chk(drops > 0, 1'b1);
        give_verdict();
    end
endmodule
